// [hdl/conditional_trap_unit.sv]
// conditional trap decode and compare stage
`timescale 1ns/10ps

// What this block does
// - register signed less-than: trap when first source below second, two's complement
// - register unsigned less-than: compare zero-extended operands, trap when first smaller
// - register not-equal: trap when both sources differ, nothing when equal
// - immediate signed less-than: sign-extend immediate, trap when register is smaller
// - immediate unsigned less-than: sign-extend immediate, compare unsigned, trap if smaller
// - unsigned immediate reaches only 0..32767 or max-32767..max
// - immediate not-equal: sign-extend immediate, trap when register differs
// - code field bits 15..12 never affect execution
// - decode reg signed trap: major 000000, minor 100000, group 111100
// - decode reg unsigned trap: same layout, minor 101000
// - decode reg not-equal trap: same layout, minor 110000
// - decode imm signed trap: major 010000, subcode 01000, immediate 15..0
// - decode imm unsigned trap: major 010000, subcode 01010
// - decode imm not-equal trap: major 010000, subcode 01100
module conditional_trap_unit
  import trap_unit_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              sys_rst_i,
  // issue from the pipeline
  input  wire logic              issue_valid_i,
  input  wire logic [WORD_W-1:0] instr_i,
  input  wire logic [WORD_W-1:0] first_source_i,
  input  wire logic [WORD_W-1:0] second_source_i,
  // result toward exception logic
  output logic                   done_o,
  output logic                   trap_req_o,
  output logic                   is_trap_instr_o,
  output logic                   reg_write_o,
  output logic [WORD_W-1:0]      trap_instr_o
);

  // all registered state in one word, so one reset branch clears every registered output
  typedef struct packed {
    logic              done;
    logic              trap;
    logic              is_trap;
    logic [WORD_W-1:0] instr;
  } state_t;

  state_t   s_q;
  state_t   s_d;
  trap_op_t op;
  logic [WORD_W-1:0] imm_ext;
  logic              cond;

  // decode; code field 15..12 is never looked at
  // a word outside the six forms decodes to none and retires quietly
  always_comb
  begin
    op = OP_NONE;
    if (instr_i[MAJOR_HI:MAJOR_LO] == MAJOR_GROUP_REG_OPS &&
        instr_i[GROUP_HI:GROUP_LO] == MINOR_GROUP_EXT_OPS)
    begin
      unique case (instr_i[MINOR_HI:MINOR_LO])
        MINOR_LT_SIGNED:   op = OP_TRAP_REG_LT_SIGNED;
        MINOR_LT_UNSIGNED: op = OP_TRAP_REG_LT_UNSIGNED;
        MINOR_NOT_EQUAL:   op = OP_TRAP_REG_NOT_EQUAL;
        default:           op = OP_NONE;
      endcase
    end
    else if (instr_i[MAJOR_HI:MAJOR_LO] == MAJOR_GROUP_IMM_OPS)
    begin
      unique case (instr_i[SUB_HI:SUB_LO])
        SUB_LT_SIGNED:   op = OP_TRAP_IMM_LT_SIGNED;
        SUB_LT_UNSIGNED: op = OP_TRAP_IMM_LT_UNSIGNED;
        SUB_NOT_EQUAL:   op = OP_TRAP_IMM_NOT_EQUAL;
        default:         op = OP_NONE;
      endcase
    end
  end

  // compare; unsigned immediate also sign-extends, so only the range ends are reachable
  always_comb
  begin
    imm_ext = {{(WORD_W-IMM_W){instr_i[IMM_HI]}}, instr_i[IMM_HI:0]};
    cond    = 1'b0;
    unique case (op)
      OP_TRAP_REG_LT_SIGNED:
        cond = $signed(first_source_i) < $signed(second_source_i);
      OP_TRAP_REG_LT_UNSIGNED:
        cond = {1'b0, first_source_i} < {1'b0, second_source_i};
      OP_TRAP_REG_NOT_EQUAL:
        cond = first_source_i != second_source_i;
      OP_TRAP_IMM_LT_SIGNED:
        cond = $signed(first_source_i) < $signed(imm_ext);
      OP_TRAP_IMM_LT_UNSIGNED:
        cond = {1'b0, first_source_i} < {1'b0, imm_ext};
      OP_TRAP_IMM_NOT_EQUAL:
        cond = first_source_i != imm_ext;
      default:
        cond = 1'b0;
    endcase
  end

  // one result per issue; trap pulse is tied to the same cycle as its own done
  // no stall path: a new issue may arrive on every cycle
  always_comb
  begin
    s_d         = s_q;
    s_d.done    = issue_valid_i;
    s_d.is_trap = issue_valid_i && (op != OP_NONE);
    s_d.trap    = issue_valid_i && cond;
    if (issue_valid_i)
    begin
      s_d.instr = instr_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign done_o          = s_q.done;
  assign trap_req_o      = s_q.trap;
  assign is_trap_instr_o = s_q.is_trap;
  // a trap never retires a result, so the write strobe stays low
  assign reg_write_o     = 1'b0;
  assign trap_instr_o    = s_q.instr;

  // checks; each rebuilds its expectation from the raw word and operands, except a_imm_range_ends, which reads imm_ext
  a_trap_needs_issue: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    trap_req_o |-> done_o && is_trap_instr_o) else $error("trap without trap issue");
  a_reg_lt_signed: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i && op == OP_TRAP_REG_LT_SIGNED |=>
    trap_req_o == ($signed($past(first_source_i)) < $signed($past(second_source_i))))
    else $error("signed register trap wrong");
  a_reg_lt_unsigned: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i && op == OP_TRAP_REG_LT_UNSIGNED |=>
    trap_req_o == ($past(first_source_i) < $past(second_source_i)))
    else $error("unsigned register trap wrong");
  a_reg_not_equal: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i && op == OP_TRAP_REG_NOT_EQUAL |=>
    trap_req_o == ($past(first_source_i) != $past(second_source_i)))
    else $error("not-equal register trap wrong");
  a_imm_lt_signed: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i && op == OP_TRAP_IMM_LT_SIGNED |=>
    trap_req_o == ($signed($past(first_source_i)) < $signed({{16{$past(instr_i[15])}},
    $past(instr_i[15:0])}))) else $error("signed immediate trap wrong");
  a_imm_lt_unsigned: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i && op == OP_TRAP_IMM_LT_UNSIGNED |=>
    trap_req_o == ($past(first_source_i) < {{16{$past(instr_i[15])}}, $past(instr_i[15:0])}))
    else $error("unsigned immediate trap wrong");
  a_imm_not_equal: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i && op == OP_TRAP_IMM_NOT_EQUAL |=>
    trap_req_o == ($past(first_source_i) != {{16{$past(instr_i[15])}}, $past(instr_i[15:0])}))
    else $error("not-equal immediate trap wrong");
  a_imm_range_ends: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    op == OP_TRAP_IMM_LT_UNSIGNED |->
    imm_ext <= IMM_UNSIGNED_LOW_MAX || imm_ext >= ~IMM_UNSIGNED_LOW_MAX)
    else $error("immediate outside range ends");
  a_no_idle_trap: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !issue_valid_i |=> !trap_req_o && !done_o) else $error("result without issue");
  a_no_reg_write: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    done_o |-> !reg_write_o) else $error("trap unit wrote a register");
  a_done_follows: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i |=> done_o) else $error("issue without result");
  a_refused_quiet: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i && op == OP_NONE |=> done_o && !trap_req_o && !is_trap_instr_o)
    else $error("non-trap word raised a trap");
  a_trap_flagged: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i && op != OP_NONE |=> is_trap_instr_o)
    else $error("trap word not flagged");
  a_word_captured: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i |=> trap_instr_o == $past(instr_i)) else $error("trap word not captured");
  a_word_held: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !issue_valid_i |=> $stable(trap_instr_o)) else $error("trap word changed while idle");
  a_reset_quiet: assert property (@(posedge core_clk_i)
    sys_rst_i ##1 sys_rst_i |-> !done_o && !trap_req_o && !is_trap_instr_o
    && trap_instr_o == '0) else $error("outputs not cleared by reset");

  // decode cross-checks against the literal encodings, not the package names
  a_decode_reg: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    op == OP_TRAP_REG_LT_SIGNED |-> instr_i[31:26] == 6'h00 && instr_i[11:6] == 6'h20
    && instr_i[5:0] == 6'h3C) else $error("register decode wrong");
  a_decode_reg_unsigned: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    op == OP_TRAP_REG_LT_UNSIGNED |-> instr_i[31:26] == 6'h00 && instr_i[11:6] == 6'h28
    && instr_i[5:0] == 6'h3C) else $error("register unsigned decode wrong");
  a_decode_reg_ne: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    op == OP_TRAP_REG_NOT_EQUAL |-> instr_i[31:26] == 6'h00 && instr_i[11:6] == 6'h30
    && instr_i[5:0] == 6'h3C) else $error("register not-equal decode wrong");
  a_decode_imm_signed: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    op == OP_TRAP_IMM_LT_SIGNED |-> instr_i[31:26] == 6'h10 && instr_i[25:21] == 5'h08)
    else $error("immediate signed decode wrong");
  a_decode_imm_unsigned: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    op == OP_TRAP_IMM_LT_UNSIGNED |-> instr_i[31:26] == 6'h10 && instr_i[25:21] == 5'h0A)
    else $error("immediate unsigned decode wrong");
  a_decode_imm_ne: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    op == OP_TRAP_IMM_NOT_EQUAL |-> instr_i[31:26] == 6'h10 && instr_i[25:21] == 5'h0C)
    else $error("immediate not-equal decode wrong");
  a_code_ignored: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    instr_i[31:26] == 6'h00 && instr_i[5:0] == 6'h3C &&
    instr_i[11:6] inside {6'h20, 6'h28, 6'h30} |-> op != OP_NONE)
    else $error("code field changed the decode");

  // main scenarios: trapping, passing, refused and back-to-back issue
  c_reg_trap: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i && op == OP_TRAP_REG_LT_SIGNED ##1 trap_req_o);
  c_imm_trap: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i && op == OP_TRAP_IMM_LT_UNSIGNED ##1 trap_req_o);
  c_no_trap: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i && op == OP_TRAP_REG_NOT_EQUAL ##1 !trap_req_o);
  c_back_to_back: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    trap_req_o ##1 trap_req_o);
  c_refused: cover property (@(posedge core_clk_i) disable iff (sys_rst_i)
    issue_valid_i && op == OP_NONE ##1 done_o && !is_trap_instr_o);

endmodule

// [hdl/trap_unit_pkg.sv]
// constants for the conditional trap unit: encodings and field positions
package trap_unit_pkg;

  localparam int unsigned WORD_W      = 32;
  localparam int unsigned IMM_W       = 16;

  // field positions in the 32-bit instruction word
  localparam int unsigned MAJOR_HI    = 31;
  localparam int unsigned MAJOR_LO    = 26;
  localparam int unsigned SUB_HI      = 25;
  localparam int unsigned SUB_LO      = 21;
  localparam int unsigned MINOR_HI    = 11;
  localparam int unsigned MINOR_LO    = 6;
  localparam int unsigned GROUP_HI    = 5;
  localparam int unsigned GROUP_LO    = 0;
  localparam int unsigned IMM_HI      = 15;

  // major opcodes and the register-form group code
  localparam logic [5:0] MAJOR_GROUP_REG_OPS = 6'h00;
  localparam logic [5:0] MAJOR_GROUP_IMM_OPS = 6'h10;
  localparam logic [5:0] MINOR_GROUP_EXT_OPS = 6'h3C;

  // register-form minor codes
  localparam logic [5:0] MINOR_LT_SIGNED   = 6'h20;
  localparam logic [5:0] MINOR_LT_UNSIGNED = 6'h28;
  localparam logic [5:0] MINOR_NOT_EQUAL   = 6'h30;

  // immediate-form subcodes
  localparam logic [4:0] SUB_LT_SIGNED     = 5'h08;
  localparam logic [4:0] SUB_LT_UNSIGNED   = 5'h0A;
  localparam logic [4:0] SUB_NOT_EQUAL     = 5'h0C;

  // largest unsigned constant reachable from the low half of the immediate
  localparam logic [WORD_W-1:0] IMM_UNSIGNED_LOW_MAX = 32'h0000_7FFF;

  // decoded operation, one-hot
  typedef enum logic [6:0] {
    OP_NONE                 = 7'h01,
    OP_TRAP_REG_LT_SIGNED   = 7'h02,
    OP_TRAP_REG_LT_UNSIGNED = 7'h04,
    OP_TRAP_REG_NOT_EQUAL   = 7'h08,
    OP_TRAP_IMM_LT_SIGNED   = 7'h10,
    OP_TRAP_IMM_LT_UNSIGNED = 7'h20,
    OP_TRAP_IMM_NOT_EQUAL   = 7'h40
  } trap_op_t;

endpackage

// [tb/issue_model.sv]
// pipeline issue model: offers one instruction and its operands per request
`timescale 1ns/10ps
module issue_model
  import trap_unit_pkg::*;
(
  // requests from the bench
  input  wire logic              core_clk_i,
  input  wire logic              req_i,
  input  wire logic [WORD_W-1:0] word_i,
  input  wire logic [WORD_W-1:0] a_i,
  input  wire logic [WORD_W-1:0] b_i,
  // toward the trap unit
  output logic                   issue_valid_o = 1'h0,
  output logic [WORD_W-1:0]      instr_o = 32'h0,
  output logic [WORD_W-1:0]      first_o = 32'h0,
  output logic [WORD_W-1:0]      second_o = 32'h0
);
  // idle lines flip so a stale word never passes as a live one
  always @(negedge core_clk_i)
  begin
    issue_valid_o <= req_i;
    instr_o       <= req_i ? word_i : ~instr_o;
    first_o       <= req_i ? a_i : ~first_o;
    second_o      <= req_i ? b_i : ~second_o;
  end
endmodule

// [tb/tb.sv]
// self-checking bench for the conditional trap unit
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
module tb;
  import trap_unit_pkg::*;
  logic        core_clk_i = 1'h0;
  logic        sys_rst_i = 1'h1;
  logic        req = 1'h0;
  logic [31:0] word = 32'h0;
  logic [31:0] opa = 32'h0;
  logic [31:0] opb = 32'h0;
  logic        iv;
  logic [31:0] ins, fs, ss, tio;
  logic        done, trap, istr, wr;
  int          err_count = 0;
  int          samples_checked = 0;
  always #25 core_clk_i = ~core_clk_i;
  issue_model pm (.core_clk_i(core_clk_i), .req_i(req), .word_i(word), .a_i(opa), .b_i(opb),
    .issue_valid_o(iv), .instr_o(ins), .first_o(fs), .second_o(ss));
  conditional_trap_unit dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .issue_valid_i(iv),
    .instr_i(ins), .first_source_i(fs), .second_source_i(ss), .done_o(done),
    .trap_req_o(trap), .is_trap_instr_o(istr), .reg_write_o(wr), .trap_instr_o(tio));
  function automatic logic [31:0] rwd(logic [5:0] mn, logic [3:0] cd);
    return {MAJOR_GROUP_REG_OPS, 5'h02, 5'h01, cd, mn, MINOR_GROUP_EXT_OPS};
  endfunction
  function automatic logic [31:0] iwd(logic [4:0] sb, logic [15:0] im);
    return {MAJOR_GROUP_IMM_OPS, sb, 5'h01, im};
  endfunction
  task automatic go(input logic [31:0] w, a, b, input logic et, ei);
    @(posedge core_clk_i);
    req <= 1'h1;
    word <= w;
    opa <= a;
    opb <= b;
    @(posedge core_clk_i);
    req <= 1'h0;
    @(negedge core_clk_i);
    `CHK("done", 1'h1, done)
    `CHK("trap", et, trap)
    `CHK("is_trap", ei, istr)
    `CHK("word", w, tio)
    `CHK("reg_write", 1'h0, wr)
    @(negedge core_clk_i);
    `CHK("pulse", 1'h0, done | trap)
  endtask
  task automatic t_reg_signed;
    go(rwd(MINOR_LT_SIGNED, 4'hF), 32'hFFFFFFFF, 32'h0, 1'h1, 1'h1);
    go(rwd(MINOR_LT_SIGNED, 4'h0), 32'h0, 32'hFFFFFFFF, 1'h0, 1'h1);
    go(rwd(MINOR_LT_SIGNED, 4'h5), 32'h5, 32'h5, 1'h0, 1'h1);
  endtask
  task automatic t_reg_unsigned;
    go(rwd(MINOR_LT_UNSIGNED, 4'h0), 32'h0, 32'hFFFFFFFF, 1'h1, 1'h1);
    go(rwd(MINOR_LT_UNSIGNED, 4'hA), 32'hFFFFFFFF, 32'h0, 1'h0, 1'h1);
    go(rwd(MINOR_LT_UNSIGNED, 4'h3), 32'h1, 32'h2, 1'h1, 1'h1);
  endtask
  task automatic t_reg_ne;
    go(rwd(MINOR_NOT_EQUAL, 4'h0), 32'h1234, 32'h1234, 1'h0, 1'h1);
    go(rwd(MINOR_NOT_EQUAL, 4'hF), 32'h1234, 32'h1235, 1'h1, 1'h1);
    go(rwd(MINOR_NOT_EQUAL, 4'h0), 32'h80000000, 32'h0, 1'h1, 1'h1);
  endtask
  task automatic t_imm_signed;
    go(iwd(SUB_LT_SIGNED, 16'h8000), 32'h80000000, 32'h0, 1'h1, 1'h1);
    go(iwd(SUB_LT_SIGNED, 16'h8000), 32'hFFFF8000, 32'h0, 1'h0, 1'h1);
    go(iwd(SUB_LT_SIGNED, 16'h0001), 32'h0, 32'hFFFFFFFF, 1'h1, 1'h1);
  endtask
  task automatic t_imm_unsigned;
    go(iwd(SUB_LT_UNSIGNED, 16'hFFFF), 32'hFFFFFFFE, 32'h0, 1'h1, 1'h1);
    go(iwd(SUB_LT_UNSIGNED, 16'hFFFF), 32'hFFFFFFFF, 32'h0, 1'h0, 1'h1);
    go(iwd(SUB_LT_UNSIGNED, 16'h7FFF), 32'h7FFE, 32'h0, 1'h1, 1'h1);
    go(iwd(SUB_LT_UNSIGNED, 16'h7FFF), 32'h7FFF, 32'h0, 1'h0, 1'h1);
    go(iwd(SUB_LT_UNSIGNED, 16'h8000), 32'h7FFFFFFF, 32'h0, 1'h1, 1'h1);
  endtask
  task automatic t_imm_ne;
    go(iwd(SUB_NOT_EQUAL, 16'hFFFF), 32'hFFFFFFFF, 32'h0, 1'h0, 1'h1);
    go(iwd(SUB_NOT_EQUAL, 16'hFFFF), 32'h0000FFFF, 32'h0, 1'h1, 1'h1);
  endtask
  task automatic t_not_trap;
    go(rwd(6'h21, 4'h0), 32'h0, 32'hFFFFFFFF, 1'h0, 1'h0);
    go(iwd(5'h09, 16'h7FFF), 32'h0, 32'h0, 1'h0, 1'h0);
    go({6'h11, SUB_NOT_EQUAL, 5'h01, 16'h0001}, 32'h0, 32'h0, 1'h0, 1'h0);
    go({26'h0000820, 6'h3D}, 32'h0, 32'h1, 1'h0, 1'h0);
  endtask
  task automatic t_back_to_back;
    @(posedge core_clk_i);
    req <= 1'h1;
    word <= rwd(MINOR_LT_SIGNED, 4'h0);
    opa <= 32'hFFFFFFFF;
    opb <= 32'h0;
    @(posedge core_clk_i);
    word <= iwd(SUB_NOT_EQUAL, 16'h0000);
    opa <= 32'h1;
    @(negedge core_clk_i);
    `CHK("b2b first done", 1'h1, done)
    `CHK("b2b first trap", 1'h1, trap)
    @(posedge core_clk_i);
    req <= 1'h0;
    @(negedge core_clk_i);
    `CHK("b2b second done", 1'h1, done)
    `CHK("b2b second trap", 1'h1, trap)
    `CHK("b2b second word", iwd(SUB_NOT_EQUAL, 16'h0000), tio)
    @(negedge core_clk_i);
    `CHK("b2b pulse", 1'h0, done | trap)
  endtask
  task automatic t_reset;
    @(negedge core_clk_i);
    sys_rst_i = 1'h1;
    req <= 1'h1;
    word <= rwd(MINOR_LT_SIGNED, 4'h0);
    opa <= 32'hFFFFFFFF;
    opb <= 32'h0;
    repeat (2) @(negedge core_clk_i);
    req <= 1'h0;
    `CHK("reset done", 1'h0, done)
    `CHK("reset trap", 1'h0, trap)
    `CHK("reset is_trap", 1'h0, istr)
    `CHK("reset word", 32'h0, tio)
    @(negedge core_clk_i);
    sys_rst_i = 1'h0;
    @(negedge core_clk_i);
    `CHK("after reset", 1'h0, done | trap)
    go(rwd(MINOR_LT_SIGNED, 4'h0), 32'hFFFFFFFF, 32'h0, 1'h1, 1'h1);
  endtask
  task automatic finish_test;
    if (err_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(negedge core_clk_i);
    sys_rst_i = 1'h0;
    t_reg_signed();
    t_reg_unsigned();
    t_reg_ne();
    t_imm_signed();
    t_imm_unsigned();
    t_imm_ne();
    t_not_trap();
    t_back_to_back();
    t_reset();
    finish_test();
  end
  // about 90 cycles of work; a wide margin covers a hung handshake
  initial
  begin
    #100000;
    err_count++;
    finish_test();
  end
endmodule
